/* File: hdl/sdm_sequencer.sv */
`timescale 1ns/1ps
`include "sdm_defines.svh"
module sdm_sequencer #(
  parameter int STST_LOG2 = `SDM_STST_LOG2,
  parameter int FASTST_LOG2 = `SDM_FASTST_LOG2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire sdm_pkg::sdm_apb_req_t apb_i,
  output sdm_pkg::sdm_apb_rsp_t apb_o,
  // Step and direction pins
  input wire logic step_i,
  input wire logic dir_i,
  // Coil drive and status
  output sdm_pkg::sdm_coil_t coil_o,
  output logic standstill_o,
  output logic [9:0] mstep_pos_o
);
  import sdm_pkg::*;

  typedef struct packed {
    logic [1:0] step_sync;
    logic [1:0] dir_sync;
    logic step_dly;
    logic [31:0] chop;
    logic [31:0] glob;
    logic [31:0] curr;
    logic [9:0] pos;
    logic [20:0] idle_cnt;
    logic stst;
    logic [20:0] period;
    logic [20:0] last_period;
    logic [12:0] tick_cnt;
    logic [8:0] left;
    logic bdir;
    sdm_mode_t mode;
    logic [31:0] prdata;
    sdm_coil_t coil;
  } sdm_state_t;

  sdm_state_t st;
  sdm_state_t next_st;

  // Step width per resolution code 0..8 (256 down to full step)
  function automatic logic [9:0] step_width(input logic [3:0] res);
    step_width = (res > 4'h8) ? 10'h100 : (10'h001 << res);
  endfunction

  // Snap to the grid of a width: offset half width, spaced one width
  function automatic logic [9:0] snap(input logic [9:0] p,
                                      input logic [9:0] w);
    logic [9:0] half;
    logic [9:0] m;
    half = w >> 1;
    m = ~(w - 10'h001);
    if (w == 10'h001)
      snap = p;
    else
      snap = ((p - half) & m) + half;
  endfunction

  // Quarter-wave sine, 256 points, amplitude 255, from a small rational formula
  function automatic logic [7:0] qsine(input logic [8:0] i);
    int x;
    int y;
    x = (i > 9'h100) ? 256 : int'(i);
    // Bhaskara approximation of sin(x*pi/512) scaled to 255
    y = (255 * 16 * x * (512 - x)) / (5 * 262144 - 4 * x * (512 - x));
    qsine = y[7:0];
  endfunction

  // Signed coil value at table position, 1024 per electrical turn
  function automatic logic [8:0] sine(input logic [9:0] p);
    logic [7:0] a;
    a = p[8] ? qsine(9'h100 - {1'b0, p[7:0]}) : qsine({1'b0, p[7:0]});
    sine = p[9] ? (9'h000 - {1'b0, a}) : {1'b0, a};
  endfunction

  logic step_evt;
  logic [9:0] width;
  logic [3:0] res;
  logic acc_wr;
  logic [20:0] st_limit;

  assign res = st.chop[27:24];
  assign width = step_width(res); // R6
  // Event on the delayed copy, never on the first sync stage
  assign step_evt = st.chop[`SDM_CHOP_DEDGE] ?
                    (st.step_sync[1] != st.step_dly) :
                    (st.step_sync[1] & ~st.step_dly); // R1 R21
  assign acc_wr = apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign st_limit = st.glob[`SDM_GLOB_FASTST] ?
                    21'(1 << FASTST_LOG2) : 21'(1 << STST_LOG2); // R15

  // Next-state logic
  always_comb
  begin
    next_st = st;
    // Two-stage synchronisers, first stage feeds only the second
    next_st.step_sync = {st.step_sync[0], step_i}; // R2
    next_st.dir_sync = {st.dir_sync[0], dir_i}; // R2
    next_st.step_dly = st.step_sync[1];

    // Register writes; a resolution change snaps the position
    if (acc_wr && apb_i.paddr[11:0] == `SDM_CHOP_OFS)
    begin
      next_st.chop = apb_i.pwdata;
      next_st.pos = snap(st.pos, step_width(apb_i.pwdata[27:24])); // R7 R8 R9 R10
    end
    if (acc_wr && apb_i.paddr[11:0] == `SDM_GLOB_OFS)
      next_st.glob = apb_i.pwdata;
    if (acc_wr && apb_i.paddr[11:0] == `SDM_CURR_OFS)
      next_st.curr = apb_i.pwdata;

    // Period measurement saturates at 21'h1F_FFFF; idle count stops at the standstill span
    if (st.period != 21'h1F_FFFF)
      next_st.period = st.period + 21'h000001;
    if (st.idle_cnt < st_limit)
      next_st.idle_cnt = st.idle_cnt + 21'h000001;
    else
      next_st.stst = 1'b1; // R15

    // Interpolated burst: one microstep per period/256
    if (st.mode == SDM_BURST)
    begin
      if (st.tick_cnt == 13'h0000)
      begin
        next_st.pos = st.bdir ? st.pos - 10'h001 : st.pos + 10'h001; // R12 R20
        next_st.left = st.left - 9'h001;
        next_st.tick_cnt = st.last_period[20:8];
        if (st.left == 9'h001)
          next_st.mode = SDM_IDLE;
      end
      else
        next_st.tick_cnt = st.tick_cnt - 13'h0001; // R14
    end

    // Active step: leftover microsteps dropped, position jumps
    if (step_evt)
    begin
      next_st.stst = 1'b0; // R16
      next_st.idle_cnt = '0;
      next_st.period = '0;
      next_st.last_period = st.period; // R18
      if (st.chop[`SDM_CHOP_INTPOL] && !st.stst && width != 10'h001)
      begin
        // R13
        next_st.pos = snap(st.pos, width) + (st.dir_sync[1] ?
                      (10'h000 - 10'h001) : 10'h001); // R18
        next_st.left = 9'(width - 10'h001);
        next_st.bdir = st.dir_sync[1];
        next_st.tick_cnt = st.period[20:8]; // R14
        // Microsteps are paced at period/256, so only a full-step burst spans the period
        next_st.mode = SDM_BURST;
      end
      else
      begin
        next_st.mode = SDM_IDLE;
        next_st.pos = st.dir_sync[1] ? snap(st.pos, width) - width
                                     : snap(st.pos, width) + width; // R5 R20
      end
    end

    // Coil outputs from the table; hold scale at standstill
    next_st.coil.coil_a = sine(st.pos); // R4 R11
    next_st.coil.coil_b = sine(st.pos + 10'h100); // R4 R11
    next_st.coil.cur_scale = st.stst ? st.curr[4:0] : st.curr[12:8]; // R17

    // Read data registered in the setup cycle
    case (apb_i.paddr[11:0])
      `SDM_CHOP_OFS: next_st.prdata = st.chop;
      `SDM_GLOB_OFS: next_st.prdata = st.glob;
      `SDM_CURR_OFS: next_st.prdata = st.curr;
      `SDM_STAT_OFS: next_st.prdata = {31'h0, st.stst};
      `SDM_POS_OFS: next_st.prdata = {22'h0, st.pos};
      default: next_st.prdata = 32'h0000_0000;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.chop <= `SDM_CHOP_RST;
      st.glob <= `SDM_GLOB_RST;
      st.curr <= `SDM_CURR_RST;
      st.mode <= SDM_IDLE;
    end
    else
      st <= next_st;
  end

  // Bus answer: ready in the first access cycle, error on unmapped address
  assign apb_o.pready = 1'b1;
  assign apb_o.prdata = st.prdata;
  assign apb_o.pslverr = apb_i.psel & apb_i.penable &
    (apb_i.paddr[11:0] > `SDM_POS_OFS || apb_i.paddr[1:0] != 2'b00);
  assign coil_o = st.coil;
  assign standstill_o = st.stst;
  assign mstep_pos_o = st.pos;

  a_stst_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_evt |=> !standstill_o) else $error("standstill not cleared"); // R16
  a_hold_scale: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.stst |=> coil_o.cur_scale == $past(st.curr[4:0]))
    else $error("hold scale not used"); // R17
  a_direct_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_evt && !st.chop[28] && !acc_wr && !st.dir_sync[1] |=>
    mstep_pos_o == 10'($past(snap(st.pos, width)) + $past(width)))
    else $error("direct step wrong"); // R5
  a_on_grid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_evt && !st.chop[28] && !acc_wr && res == 4'h8 |=>
    mstep_pos_o[7:0] == 8'h80) else $error("full step off grid"); // R8
  a_single_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !st.chop[29] && !st.step_sync[1] && st.step_dly |-> !step_evt)
    else $error("falling edge counted"); // R1
  a_sync_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.step_dly == $past(st.step_sync[1])) else $error("sync order"); // R21
  a_stst_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.idle_cnt >= st_limit && !step_evt |=> standstill_o)
    else $error("standstill late"); // R15
  a_wrap_pos: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_evt && !st.chop[28] && !acc_wr && res == 4'h0 && st.pos == 10'h3FF
    && !st.dir_sync[1] |=> mstep_pos_o == 10'h000)
    else $error("no wrap"); // R20

  // Step kinds used by the grid and burst checks below
  sequence s_half_step;
    step_evt && !st.chop[28] && !acc_wr && res == 4'h7;
  endsequence
  sequence s_quarter_step;
    step_evt && !st.chop[28] && !acc_wr && res == 4'h6;
  endsequence
  sequence s_intp_step;
    step_evt && st.chop[28] && !st.stst && !acc_wr && width != 10'h001;
  endsequence
  sequence s_burst_tick;
    st.mode == SDM_BURST && st.tick_cnt == 13'h0000 && !step_evt && !acc_wr;
  endsequence

  // Both edges count in double-edge mode
  a_dedge_both: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.chop[29] && st.step_sync[1] != st.step_dly |-> step_evt)
    else $error("edge missed in double-edge mode"); // R1
  // Second stage only ever copies the first
  a_sync_stage: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.step_sync[1] == $past(st.step_sync[0]))
    else $error("sync stage skipped"); // R2
  // Direction high moves backwards by the width
  a_direct_back: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_evt && !st.chop[28] && !acc_wr && st.dir_sync[1] |=>
    mstep_pos_o == 10'($past(snap(st.pos, width)) - $past(width)))
    else $error("backward step wrong"); // R5
  // Half and quarter grids keep their offsets
  a_half_grid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_half_step |=> mstep_pos_o[6:0] == 7'h40)
    else $error("half step off grid"); // R9
  a_quarter_grid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_quarter_step |=> mstep_pos_o[5:0] == 6'h20)
    else $error("quarter step off grid"); // R10
  // Table start and full-step level
  a_zero_pos: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.pos == 10'h000 |=> coil_o.coil_a == 9'h000 && coil_o.coil_b == 9'h0FF)
    else $error("table origin wrong"); // R4
  a_full_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.pos == 10'h080 |=> coil_o.coil_a == 9'h0B4 && coil_o.coil_b == 9'h0B4)
    else $error("full step level wrong"); // R11
  // Interpolation starts a burst only when enabled
  a_burst_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_intp_step |=> st.mode == SDM_BURST)
    else $error("burst not started"); // R12
  a_no_intp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_evt && !st.chop[28] |=> st.mode == SDM_IDLE)
    else $error("burst while disabled"); // R13
  // Each burst tick moves one table entry
  a_burst_move: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_burst_tick |=> mstep_pos_o == 10'($past(st.bdir) ?
    $past(st.pos) - 10'h001 : $past(st.pos) + 10'h001))
    else $error("burst tick wrong"); // R14
  // Step period taken for the next burst
  a_period_last: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_evt |=> st.last_period == $past(st.period))
    else $error("period not kept"); // R18
  // Run scale while moving
  a_run_scale: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !st.stst |=> coil_o.cur_scale == $past(st.curr[12:8]))
    else $error("run scale not used"); // R17
  // Backward wrap at the table start
  a_wrap_back: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_evt && !st.chop[28] && !acc_wr && res == 4'h0 && st.pos == 10'h000
    && st.dir_sync[1] |=> mstep_pos_o == 10'h3FF)
    else $error("no backward wrap"); // R20
endmodule // sdm_sequencer

/* File: hdl/sdm_defines.svh */
`ifndef SDM_DEFINES_SVH
`define SDM_DEFINES_SVH
// How it works
// R1: Double-edge bit set makes both step edges active, else rising only.
// R2: Step and direction pins are synchronised before the sequencer uses them.
// R3: Controller keeps step rate at most half clock, quarter in double-edge.
// R4: Sine table of 1024 positions covers four full steps.
// R5: Direction low adds step width, direction high subtracts it.
// R6: Step width is 1 at finest, doubling per halving, 256 at full step.
// R7: Resolution may change anytime; coarser moves counter to nearest grid point. The code snaps to the grid point at or below.
// R8: Full step visits 128, 384, 640, 896, moving 256 per step.
// R9: Half step grid starts at 64, spaced 128.
// R10: Quarter step grid starts at 32, spaced 64; zero/peak never used.
// R11: Full-step points give 70.7 percent; half-step points 38.3 and 92.4.
// R12: Interpolation turns each step into a 256x microstep burst. The code makes the first step after standstill a direct width move.
// R13: Interpolation only while its enable bit is set, else direct width moves.
// R14: Previous period measured, divided into 256 parts, up to 2^20 clocks.
// R15: Standstill flag after 2^20 clocks without steps, 2^18 when fast.
// R16: Next active step clears the standstill flag.
// R17: Standstill selects hold current scale instead of run scale.
// R18: New rate used after one period; a new step drops unsent microsteps.
// R19: Controller should give stable rate and 50 percent duty for double-edge.
// R20: Counter is 10 bits, wrapping modulo table length both ways.
// R21: Edges found against a one-cycle-delayed copy, one event per transition.

// APB register offsets
`define SDM_CHOP_OFS 12'h000
`define SDM_GLOB_OFS 12'h004
`define SDM_CURR_OFS 12'h008
`define SDM_STAT_OFS 12'h00C
`define SDM_POS_OFS 12'h010
// Field positions
`define SDM_CHOP_DEDGE 29
`define SDM_CHOP_INTPOL 28
`define SDM_GLOB_FASTST 0
// Reset values: resolution code 0 is 256 microsteps
`define SDM_CHOP_RST 32'h1000_0000
`define SDM_GLOB_RST 32'h0000_0000
`define SDM_CURR_RST 32'h0000_0A1F
// Timing counts in clocks
`define SDM_STST_LOG2 20
`define SDM_FASTST_LOG2 18
`define SDM_TABLE_LEN 1024
`endif

/* File: hdl/sdm_pkg.sv */
package sdm_pkg;
  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } sdm_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sdm_apb_rsp_t;
  typedef struct packed {
    logic [8:0] coil_a;
    logic [8:0] coil_b;
    logic [4:0] cur_scale;
  } sdm_coil_t;
  typedef enum logic {SDM_IDLE, SDM_BURST} sdm_mode_t;
endpackage

/* File: verification/sdm_step_src.sv */
`timescale 1ns/1ps
module sdm_step_src (
  // Clock
  input wire logic clk_i,
  // Pins toward the sequencer
  output logic step_o,
  output logic dir_o
);
  // Pins idle low until the first step is asked for
  initial
  begin
    step_o = 1'b0;
    dir_o = 1'b0;
  end
  // One active edge: two clocks of direction setup, then at least two
  // clocks high and low, so the rate stays well inside the input limit
  task automatic send(input logic d, input logic both, input int gap);
    dir_o <= d;
    repeat (2) @(posedge clk_i);
    step_o <= both ? ~step_o : 1'b1;
    repeat (2) @(posedge clk_i);
    if (!both)
      step_o <= 1'b0;
    repeat (4 + gap) @(posedge clk_i);
  endtask
endmodule // sdm_step_src

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
  num_errors++; $display("BAD %s exp %0h got %0h", n, e, a); end end
module tb_top;
  import sdm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  sdm_apb_req_t req = '0;
  sdm_apb_rsp_t rsp;
  sdm_coil_t coil;
  logic stst, step, dir, rerr;
  logic [9:0] pos_o;
  logic [31:0] rdata, r;
  logic [31:0] seed = 32'h0000_94FF;
  int num_errors = 0;
  int comparisons = 0;
  int pos = 0;
  int res = 0;
  int d;

  // Clock of 100 ns period
  always #50 clk_i = ~clk_i;

  // Standstill counts shortened so the timeouts fit a short run
  sdm_sequencer #(.STST_LOG2(12), .FASTST_LOG2(10)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(req), .apb_o(rsp),
    .step_i(step), .dir_i(dir), .coil_o(coil), .standstill_o(stst),
    .mstep_pos_o(pos_o));
  sdm_step_src src_u (.clk_i(clk_i), .step_o(step), .dir_o(dir));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // One APB transfer; an idle edge first keeps psel from toggling twice
  task automatic apb(input logic [31:0] a, input logic w,
                     input logic [31:0] v);
    @(posedge clk_i);
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= v;
    req.psel <= 1'b1;
    @(posedge clk_i);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Resolution write: model moves to the grid point at or below
  task automatic chop(input logic [31:0] v);
    int w;
    apb(32'h0000_0000, 1'b1, v);
    res = v[27:24];
    w = 1 << res;
    pos = ((((pos - w / 2) & 1023) & ~(w - 1)) + w / 2) & 1023;
    repeat (4) @(posedge clk_i);
    `CHK("pos_snap", pos[9:0], pos_o)
  endtask

  // Step through the partner, model moves by the full width
  task automatic stp(input logic dr, input logic both, input int gap);
    src_u.send(dr, both, gap);
    pos = (pos + (dr ? -(1 << res) : (1 << res))) & 1023;
    `CHK("pos", pos[9:0], pos_o)
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well past the expected run length
  initial
  begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(32'h0000_0000, 1'b0, 32'h0);
    `CHK("chop_rst", 32'h1000_0000, rdata)
    apb(32'h0000_0014, 1'b0, 32'h0);
    `CHK("slverr", 1'b1, rerr)
    chop(32'h2000_0000);
    repeat (4)
    begin
      r = rnd();
      stp(r[0], 1'b1, 0);
    end
    for (int i = 0; i < 18; i++)
    begin
      chop({4'h0, 4'(i % 9), 24'h0});
      repeat (5)
      begin
        r = rnd();
        stp(r[0], 1'b0, int'(r[3:1]));
      end
      apb(32'h0000_0010, 1'b0, 32'h0);
      `CHK("pos_reg", {22'h0, pos[9:0]}, rdata)
    end
    `CHK("coil_a", 9'(pos < 512 ? 180 : -180), coil.coil_a)
    `CHK("coil_b", 9'(((pos + 256) & 1023) < 512 ? 180 : -180), coil.coil_b)
    repeat (4200) @(posedge clk_i);
    `CHK("stst", 1'b1, stst)
    `CHK("hold", 5'h1F, coil.cur_scale)
    stp(1'b0, 1'b0, 0);
    `CHK("stst_clr", 1'b0, stst)
    `CHK("run", 5'h0A, coil.cur_scale)
    apb(32'h0000_0004, 1'b1, 32'h1);
    stp(1'b1, 1'b0, 0);
    repeat (1100) @(posedge clk_i);
    `CHK("stst_fast", 1'b1, stst)
    apb(32'h0000_0004, 1'b1, 32'h0);
    chop(32'h1800_0000);
    stp(1'b0, 1'b0, 2552);
    src_u.send(1'b0, 1'b0, 1272);
    d = (int'(pos_o) - pos) & 1023;
    `CHK("burst_mid", 1'b1, (d > 0 && d < 256))
    repeat (1400) @(posedge clk_i);
    pos = (pos + 256) & 1023;
    `CHK("burst_end", pos[9:0], pos_o)
    end_of_test();
  end
endmodule // tb_top
